// ==== rtl/sgt_scan_guard_timer.sv ====
`timescale 1ns/1ps

// How it works
// - Set command loads timeout as N times 10ms
// - Quarter second timeout after reset
// - Programmed timeout holds until reprogrammed
// - Counter runs in hardware on own clock
// - Retrigger clears elapsed count, restarts counting
// - Count reaching timeout shuts controller down
// - Expiry forces all I/O off
module sgt_scan_guard_timer #(
  // Tick length is open so a bench can shorten the time base
  parameter int unsigned TICK_LEN = sgt_pkg::TICK_CYCLES
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire sgt_pkg::sgt_cmd_t cmd,
  output logic [6:0]           timeout_n_active,
  output logic                 shutdown,
  output logic                 io_off
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  sgt_pkg::sgt_state_t state;
  sgt_pkg::sgt_state_t next_state;
  logic [20:0]         tick_cnt;
  logic [20:0]         next_tick_cnt;
  logic [6:0]          elapsed;
  logic [6:0]          next_elapsed;
  logic [6:0]          timeout_n;
  logic [6:0]          next_timeout_n;
  logic                set_edge_q;
  logic                next_set_edge_q;
  logic                tick;
  logic                load;

  // Out-of-range N is ignored so a bad value cannot disable the guard
  function automatic logic n_valid(input logic [6:0] n);
    n_valid = (n >= sgt_pkg::N_MIN) && (n <= sgt_pkg::N_MAX);
  endfunction : n_valid

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    tick = (tick_cnt == 21'(TICK_LEN - 1));
    load = (cmd.set_level || (cmd.set_edge && !set_edge_q))
           && n_valid(cmd.timeout_n);
    next_set_edge_q = cmd.set_edge;
    next_timeout_n  = load ? cmd.timeout_n : timeout_n;
    next_state      = state;
    next_tick_cnt   = tick ? 21'h00_0000 : tick_cnt + 21'h00_0001;
    next_elapsed    = elapsed;
    unique case (state)
      sgt_pkg::SGT_RUN: begin
        if (cmd.kick) begin
          // Tick phase restarts too, so the full period is always granted
          next_elapsed  = 7'h00;
          next_tick_cnt = 21'h00_0000;
        end else if (tick) begin
          next_elapsed = elapsed + 7'h01;
          if (elapsed + 7'h01 >= timeout_n) begin
            next_state = sgt_pkg::SGT_EXPIRED;
          end
        end
      end
      sgt_pkg::SGT_EXPIRED: begin
        next_state    = sgt_pkg::SGT_EXPIRED;
        next_tick_cnt = 21'h00_0000;
      end
      default: begin
        next_state = sgt_pkg::SGT_EXPIRED;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= sgt_pkg::SGT_RUN;
      tick_cnt   <= 21'h00_0000;
      elapsed    <= 7'h00;
      timeout_n  <= sgt_pkg::N_DEFAULT;
      set_edge_q <= 1'b0;
    end else begin
      state      <= next_state;
      tick_cnt   <= next_tick_cnt;
      elapsed    <= next_elapsed;
      timeout_n  <= next_timeout_n;
      set_edge_q <= next_set_edge_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shutdown         <= 1'b0;
      io_off           <= 1'b0;
      timeout_n_active <= sgt_pkg::N_DEFAULT;
    end else begin
      shutdown         <= (next_state == sgt_pkg::SGT_EXPIRED);
      io_off           <= (next_state == sgt_pkg::SGT_EXPIRED);
      timeout_n_active <= next_timeout_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_default_timeout;
    @(posedge clk) $fell(rst) |-> timeout_n == sgt_pkg::N_DEFAULT;
  endproperty
  a_default_timeout: assert property (p_default_timeout)
    else $error("Default timeout not 25 ticks");

  property p_load_level;
    @(posedge clk) disable iff (rst)
      cmd.set_level && n_valid(cmd.timeout_n)
      |=> timeout_n == $past(cmd.timeout_n);
  endproperty
  a_load_level: assert property (p_load_level)
    else $error("Level set did not load timeout");

  property p_hold_timeout;
    @(posedge clk) disable iff (rst)
      !load |=> $stable(timeout_n);
  endproperty
  a_hold_timeout: assert property (p_hold_timeout)
    else $error("Timeout changed without a set");

  property p_kick_clears;
    @(posedge clk) disable iff (rst)
      cmd.kick && state == sgt_pkg::SGT_RUN
      |=> elapsed == 7'h00 && tick_cnt == 21'h00_0000;
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("Kick did not clear count");

  property p_tick_counts;
    @(posedge clk) disable iff (rst)
      state == sgt_pkg::SGT_RUN && !cmd.kick && !tick
      |=> tick_cnt == $past(tick_cnt) + 21'h00_0001;
  endproperty
  a_tick_counts: assert property (p_tick_counts)
    else $error("Time base stalled");

  property p_expire;
    @(posedge clk) disable iff (rst)
      state == sgt_pkg::SGT_RUN && tick && !cmd.kick
      && elapsed + 7'h01 >= timeout_n
      |=> shutdown && io_off;
  endproperty
  a_expire: assert property (p_expire)
    else $error("Timeout reached without shutdown");

  property p_io_with_shutdown;
    @(posedge clk) disable iff (rst) io_off == shutdown;
  endproperty
  a_io_with_shutdown: assert property (p_io_with_shutdown)
    else $error("I/O off disagrees with shutdown");

  property p_latched;
    @(posedge clk) disable iff (rst) shutdown |=> shutdown [*4];
  endproperty
  a_latched: assert property (p_latched)
    else $error("Shutdown released before reset");

  property p_no_early;
    @(posedge clk) disable iff (rst)
      $rose(shutdown) |-> $past(elapsed) + 7'h01 >= $past(timeout_n);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("Shutdown before timeout");

  property p_edge_load;
    @(posedge clk) disable iff (rst)
      cmd.set_edge && !set_edge_q && n_valid(cmd.timeout_n)
      |=> timeout_n == $past(cmd.timeout_n);
  endproperty
  a_edge_load: assert property (p_edge_load)
    else $error("Edge set did not load timeout");

  // A bad count must never replace a good one
  property p_reject_bad_n;
    @(posedge clk) disable iff (rst)
      !n_valid(cmd.timeout_n) |=> $stable(timeout_n);
  endproperty
  a_reject_bad_n: assert property (p_reject_bad_n)
    else $error("Out-of-range count was loaded");

  property p_active_follows;
    @(posedge clk) disable iff (rst)
      load |=> timeout_n_active == $past(cmd.timeout_n);
  endproperty
  a_active_follows: assert property (p_active_follows)
    else $error("Active timeout did not follow set");

  property p_elapsed_hold;
    @(posedge clk) disable iff (rst)
      state == sgt_pkg::SGT_RUN && !cmd.kick && !tick
      |=> $stable(elapsed);
  endproperty
  a_elapsed_hold: assert property (p_elapsed_hold)
    else $error("Elapsed count moved between ticks");

  property p_elapsed_step;
    @(posedge clk) disable iff (rst)
      state == sgt_pkg::SGT_RUN && !cmd.kick && tick
      |=> elapsed == $past(elapsed) + 7'h01;
  endproperty
  a_elapsed_step: assert property (p_elapsed_step)
    else $error("Elapsed count missed a tick");

  property p_tick_wrap;
    @(posedge clk) disable iff (rst)
      tick |=> tick_cnt == 21'h00_0000;
  endproperty
  a_tick_wrap: assert property (p_tick_wrap)
    else $error("Time base did not wrap");

  property p_stay_expired;
    @(posedge clk) disable iff (rst)
      state == sgt_pkg::SGT_EXPIRED |=> state == sgt_pkg::SGT_EXPIRED;
  endproperty
  a_stay_expired: assert property (p_stay_expired)
    else $error("Expired state left before reset");

  // Kicks after expiry must not touch anything
  property p_kick_after_expiry;
    @(posedge clk) disable iff (rst)
      shutdown && cmd.kick
      |=> shutdown && io_off && elapsed == $past(elapsed);
  endproperty
  a_kick_after_expiry: assert property (p_kick_after_expiry)
    else $error("Kick acted after expiry");

endmodule : sgt_scan_guard_timer

// ==== rtl/sgt_pkg.sv ====
package sgt_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W        = 21;

  // Timeout count N, in ticks of TICK_MS
  localparam int unsigned N_W           = 7;
  localparam logic [6:0]  N_MIN         = 7'h05;
  localparam logic [6:0]  N_MAX         = 7'h78;
  // Default period 0.25 s
  localparam int unsigned DEFAULT_MS    = 250;
  localparam logic [6:0]  N_DEFAULT     = 7'(DEFAULT_MS / TICK_MS);

  typedef enum logic [1:0] {
    SGT_RUN     = 2'b01,
    SGT_EXPIRED = 2'b10
  } sgt_state_t;

  // Command group from the processor
  typedef struct packed {
    logic       set_level;   // Level-acting load variant
    logic       set_edge;    // Rising-edge load variant
    logic [6:0] timeout_n;
    logic       kick;        // Retrigger pulse
  } sgt_cmd_t;

endpackage : sgt_pkg

// ==== dv/sgt_cpu_model.sv ====
`timescale 1ns/1ps
module sgt_cpu_model #(
  parameter int SCAN = 40
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [6:0]   n,
  input  wire logic         lvl,
  input  wire logic         edg,
  input  wire logic         run,
  input  wire logic         extra,
  output sgt_pkg::sgt_cmd_t cmd
);
  int cnt;
  // Housekeeping kick at the end of every scan while run is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      cmd <= '0;
    end else begin
      cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
      cmd.kick <= extra || (run && cnt == SCAN - 1);
      cmd.timeout_n <= n;
      cmd.set_level <= lvl;
      cmd.set_edge <= edg;
    end
  end
endmodule : sgt_cpu_model

// ==== dv/scan_watchdog_timer_bench.sv ====
`timescale 1ns/1ps
module scan_watchdog_timer_bench;
  logic              clk = 0;
  logic              rst = 1;
  logic [6:0]        n = 7'h19;
  logic              lvl = 0;
  logic              edg = 0;
  logic              run = 1;
  logic              extra = 0;
  // Short tick so expiry fits the run
  localparam int     TICK = 16;
  sgt_pkg::sgt_cmd_t cmd;
  logic [6:0]        act;
  logic              sd;
  logic              off;
  int                mismatches = 0;
  int                total_checks = 0;
  int                cyc = 0;
  always #2.5 clk = ~clk;
  sgt_cpu_model sgt_cpu_model_inst (.clk(clk), .rst(rst), .n(n),
    .lvl(lvl), .edg(edg), .run(run), .extra(extra), .cmd(cmd));
  sgt_scan_guard_timer #(.TICK_LEN(TICK)) sgt_scan_guard_timer_inst (
    .clk(clk), .rst(rst),
    .cmd(cmd), .timeout_n_active(act), .shutdown(sd), .io_off(off));
  task automatic check(string nm, logic [6:0] exp, logic [6:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Model adds one cycle, design one more
  task automatic drive(logic [6:0] v, logic l, logic e);
    @(posedge clk);
    n <= v;
    lvl <= l;
    edg <= e;
    repeat (3) @(posedge clk);
    #1;
  endtask : drive
  task automatic do_reset();
    @(posedge clk);
    rst <= 1;
    lvl <= 0;
    edg <= 0;
    run <= 1;
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    check("timeout", 7'h19, act);
    check("io", 7'h00, {5'h0_0, sd, off});
    $display("reset test done");
  endtask : do_reset
  task automatic t_level();
    drive(7'h05, 1, 0);
    check("timeout", 7'h05, act);
    drive(7'h78, 1, 0);
    check("timeout", 7'h78, act);
    drive(7'h04, 1, 0);
    check("timeout", 7'h78, act);
    drive(7'h79, 1, 0);
    check("timeout", 7'h78, act);
    drive(7'h30, 0, 0);
    check("timeout", 7'h78, act);
    $display("level test done");
  endtask : t_level
  task automatic t_edge();
    drive(7'h0a, 0, 1);
    check("timeout", 7'h0a, act);
    drive(7'h14, 0, 1);
    check("timeout", 7'h0a, act);
    drive(7'h14, 0, 0);
    drive(7'h14, 0, 1);
    check("timeout", 7'h14, act);
    check("io", 7'h00, {5'h0_0, sd, off});
    $display("edge test done");
  endtask : t_edge
  task automatic kick_once();
    @(posedge clk);
    extra <= 1;
    @(posedge clk);
    extra <= 0;
  endtask : kick_once
  // Design takes the kick on the third edge after kick_once starts
  task automatic t_expire();
    drive(7'h05, 1, 0);
    check("timeout", 7'h05, act);
    drive(7'h05, 0, 0);
    @(posedge clk);
    run <= 0;
    repeat (3) begin
      kick_once();
      repeat (4 * TICK + 6) @(posedge clk);
    end
    #1;
    check("shutdown", 7'h00, {5'h0_0, sd, off});
    kick_once();
    repeat (5 * TICK) @(posedge clk);
    #1;
    check("shutdown", 7'h00, {5'h0_0, sd, off});
    @(posedge clk);
    #1;
    check("shutdown", 7'h03, {5'h0_0, sd, off});
    @(posedge clk);
    run <= 1;
    kick_once();
    drive(7'h78, 1, 0);
    repeat (120) @(posedge clk);
    #1;
    check("timeout", 7'h78, act);
    check("shutdown", 7'h03, {5'h0_0, sd, off});
    $display("expiry test done");
  endtask : t_expire
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Ceiling well above the few hundred cycles used
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    do_reset();
    t_level();
    t_edge();
    t_expire();
    do_reset();
    complete_run();
  end
endmodule : scan_watchdog_timer_bench
